// ---- inc/idt_pkg.sv ----
// constants, opcode patterns and decode types for instruction decode timing
package idt_pkg;

	// ========================================================================
	// widths and timing
	localparam int IDT_INSTR_W       = 14;
	localparam int IDT_CLK_PER_CYCLE = 4;
	localparam int IDT_RD_PHASE      = 1;
	localparam int IDT_FILE_MAX      = 8'h7f;
	localparam logic [5:0] IDT_IND_HI = 6'h00;

	// ========================================================================
	// opcode patterns, matched as (word & mask) == value
	localparam logic [13:0] IDT_OP_CALL     = 14'h2000;
	localparam logic [13:0] IDT_MK_CALL     = 14'h3800;
	localparam logic [13:0] IDT_OP_JUMP     = 14'h2800;
	localparam logic [13:0] IDT_MK_JUMP     = 14'h3800;
	localparam logic [13:0] IDT_OP_RBRA     = 14'h3200;
	localparam logic [13:0] IDT_MK_RBRA     = 14'h3e00;
	localparam logic [13:0] IDT_OP_CALLACC  = 14'h000a;
	localparam logic [13:0] IDT_OP_BRACC    = 14'h000b;
	localparam logic [13:0] IDT_OP_RET      = 14'h0008;
	localparam logic [13:0] IDT_OP_RETINT   = 14'h0009;
	localparam logic [13:0] IDT_MK_EXACT    = 14'h3fff;
	localparam logic [13:0] IDT_OP_RETLIT   = 14'h3400;
	localparam logic [13:0] IDT_OP_DECSKIP  = 14'h0b00;
	localparam logic [13:0] IDT_OP_INCSKIP  = 14'h0f00;
	localparam logic [13:0] IDT_MK_BYTEOP   = 14'h3f00;
	localparam logic [13:0] IDT_OP_SKIPCLR  = 14'h1800;
	localparam logic [13:0] IDT_OP_SKIPSET  = 14'h1c00;
	localparam logic [13:0] IDT_MK_BITOP    = 14'h3c00;
	localparam logic [13:0] IDT_OP_CLRACC   = 14'h0100;
	localparam logic [13:0] IDT_MK_CLRACC   = 14'h3ffc;
	localparam logic [13:0] IDT_OP_PTRINC   = 14'h0010;
	localparam logic [13:0] IDT_MK_PTRINC   = 14'h3ff0;
	localparam logic [13:0] IDT_OP_PTROFS   = 14'h3f00;
	localparam logic [13:0] IDT_MK_PTROFS   = 14'h3f00;

	// ========================================================================
	// decode types
	typedef enum logic [1:0] {
		IDT_FMT_BYTE,
		IDT_FMT_BIT,
		IDT_FMT_LIT
	} idt_fmt_type;

	typedef enum logic [2:0] {
		IDT_CLS_PLAIN,
		IDT_CLS_CALL,
		IDT_CLS_RETURN,
		IDT_CLS_BRANCH,
		IDT_CLS_SKIP_ZERO,
		IDT_CLS_SKIP_CLR,
		IDT_CLS_SKIP_SET
	} idt_cls_type;

	typedef enum logic [1:0] {
		IDT_MODE_PRE_INC,
		IDT_MODE_PRE_DEC,
		IDT_MODE_POST_INC,
		IDT_MODE_POST_DEC
	} idt_mode_type;

	typedef struct packed {
		idt_fmt_type  fmt;
		idt_cls_type  cls;
		logic         file_acc;
		logic         file_wr;
		logic         acc_wr;
		logic         indirect;
		logic         ptr_sel;
		logic [6:0]   file_addr;
		logic [2:0]   bit_sel;
		logic [7:0]   literal;
		logic [10:0]  target;
		logic [8:0]   offset;
		logic [5:0]   ptr_ofs;
		idt_mode_type mode;
	} idt_dec_type;

endpackage

// ---- src/idt_instruction_decode_timing.sv ----
// instruction decode and instruction-cycle timing for the 8-bit core
`timescale 1ns/1ns
// What this block does
// - each instruction is one 14-bit word with opcode and all operands.
// - every opcode sorts into byte, bit, or literal/control format.
// - instructions outside the exceptions finish in one instruction cycle.
// - direct call and call-by-accumulator take two cycles.
// - return, return with literal, return from interrupt take two cycles.
// - jumps, branches and taken skips take two cycles.
// - indirect access while pointer aims at program memory adds a cycle.
// - one instruction cycle is four oscillator clocks.
// - file instructions read, modify, then store per instruction or d.
// - the file register is read even when only written.
// - file address spans 0x00 to 0x7f within one bank.
// - bit operand picks one bit of the 8-bit file register.
// - d zero stores to accumulator, d one stores to file register.
// - don't-care bits do not change execution.
// - pointer operand selects file select pointer zero or one.
// - increment forms carry pre/post increment/decrement mode.
// - literal operands come straight from the literal field.
// - bit select field is 3 bits, file address 7 bits.
// - call and jump carry an 11-bit target in the low bits.
// - relative branch carries a 9-bit offset field.
module idt_instruction_decode_timing #(
	parameter int INSTR_W       = idt_pkg::IDT_INSTR_W,
	parameter int CLK_PER_CYCLE = idt_pkg::IDT_CLK_PER_CYCLE
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// program memory side
	input  wire logic [INSTR_W-1:0]   instr_word,
	output logic                      instr_take,
	// datapath status
	input  wire logic [1:0]           ptr_in_prog,
	input  wire logic                 alu_zero,
	input  wire logic                 tested_bit,
	// decoded instruction
	output idt_pkg::idt_dec_type      dec,
	output logic                      exec_active,
	output logic                      nop_cycle,
	output logic                      stall_cycle,
	// timing
	output logic [1:0]                phase,
	output logic                      cycle_end,
	// file register access strobes
	output logic                      file_rd,
	output logic                      file_wr,
	output logic                      acc_wr,
	// completion
	output logic                      instr_done,
	output logic [1:0]                instr_cycles
);
	import idt_pkg::*;

	// ========================================================================
	// elaboration checks
	initial begin
		if (INSTR_W != IDT_INSTR_W)
			$error("instruction word must be 14 bits");
		if (CLK_PER_CYCLE != IDT_CLK_PER_CYCLE)
			$error("instruction cycle must span four clocks");
		// the read strobe must land before the store strobe of the cycle
		if (IDT_RD_PHASE >= CLK_PER_CYCLE - 1)
			$error("file read slot must precede the store slot");
		if (IDT_FILE_MAX != (1 << 7) - 1)
			$error("file address field must be 7 bits");
		if ($bits(idt_dec_type) != 56)
			$error("decoded word layout changed");
	end

	// ========================================================================
	// decode functions
	function automatic logic op_is(input logic [13:0] w,
		input logic [13:0] val, input logic [13:0] mask);
		op_is = (w & mask) == val;
	endfunction

	// cycle class of a word; skips are sorted by the condition they test
	function automatic idt_cls_type cls_of(input logic [13:0] w);
		if (op_is(w, IDT_OP_CALL, IDT_MK_CALL) ||
			op_is(w, IDT_OP_CALLACC, IDT_MK_EXACT))
			cls_of = IDT_CLS_CALL;
		else if (op_is(w, IDT_OP_RET, IDT_MK_EXACT) ||
			op_is(w, IDT_OP_RETINT, IDT_MK_EXACT) ||
			op_is(w, IDT_OP_RETLIT, IDT_MK_BYTEOP))
			cls_of = IDT_CLS_RETURN;
		else if (op_is(w, IDT_OP_JUMP, IDT_MK_JUMP) ||
			op_is(w, IDT_OP_RBRA, IDT_MK_RBRA) ||
			op_is(w, IDT_OP_BRACC, IDT_MK_EXACT))
			cls_of = IDT_CLS_BRANCH;
		else if (op_is(w, IDT_OP_DECSKIP, IDT_MK_BYTEOP) ||
			op_is(w, IDT_OP_INCSKIP, IDT_MK_BYTEOP))
			cls_of = IDT_CLS_SKIP_ZERO;
		else if (op_is(w, IDT_OP_SKIPCLR, IDT_MK_BITOP))
			cls_of = IDT_CLS_SKIP_CLR;
		else if (op_is(w, IDT_OP_SKIPSET, IDT_MK_BITOP))
			cls_of = IDT_CLS_SKIP_SET;
		else
			cls_of = IDT_CLS_PLAIN;
	endfunction

	function automatic idt_dec_type decode(input logic [13:0] w);
		idt_dec_type r;
		logic        byte_lit;
		logic        ptr_inc;
		logic        ptr_ofs;
		r        = '0;
		// five byte-format opcodes live in the 11 group
		byte_lit = (w[13:12] == 2'b11) && ((w[11:8] == 4'h5) ||
			(w[11:8] == 4'h6) || (w[11:8] == 4'h7) ||
			(w[11:8] == 4'hb) || (w[11:8] == 4'hd));
		ptr_inc  = op_is(w, IDT_OP_PTRINC, IDT_MK_PTRINC);
		ptr_ofs  = op_is(w, IDT_OP_PTROFS, IDT_MK_PTROFS);
		if (w[13:12] == 2'b01)
			r.fmt = IDT_FMT_BIT;
		else if (((w[13:12] == 2'b00) && (w[11:7] != 5'h00)) || byte_lit)
			r.fmt = IDT_FMT_BYTE;
		else
			r.fmt = IDT_FMT_LIT;
		// operand fields, straight slices of the word
		r.file_addr = w[6:0];
		r.bit_sel   = w[9:7];
		r.literal   = w[7:0];
		r.target    = w[10:0];
		r.offset    = w[8:0];
		r.ptr_ofs   = w[5:0];
		r.mode      = idt_mode_type'(w[1:0]);
		// cycle class
		r.cls = cls_of(w);
		// read-modify-write targets
		if (r.fmt == IDT_FMT_BYTE) begin
			r.file_acc = !op_is(w, IDT_OP_CLRACC, IDT_MK_CLRACC);
			r.file_wr  = r.file_acc && w[7];
			r.acc_wr   = !w[7];
		end else if (r.fmt == IDT_FMT_BIT) begin
			r.file_acc = 1'b1;
			r.file_wr  = !w[11];
		end else begin
			r.acc_wr   = op_is(w, IDT_OP_RETLIT, IDT_MK_BYTEOP);
		end
		// indirect port, pointer picked by the low address bit, or by w[2] / w[6] in the pointer forms
		if (r.file_acc && (w[6:1] == IDT_IND_HI)) begin
			r.indirect = 1'b1;
			r.ptr_sel  = w[0];
		end else if (ptr_inc) begin
			r.indirect = 1'b1;
			r.ptr_sel  = w[2];
		end else if (ptr_ofs) begin
			r.indirect = 1'b1;
			r.ptr_sel  = w[6];
		end
		return r;
	endfunction

	function automatic logic needs_flush(input idt_dec_type d,
		input logic zero, input logic bitv);
		unique case (d.cls)
			IDT_CLS_CALL, IDT_CLS_RETURN, IDT_CLS_BRANCH:
				needs_flush = 1'b1;
			IDT_CLS_SKIP_ZERO: needs_flush = zero;
			IDT_CLS_SKIP_CLR:  needs_flush = !bitv;
			IDT_CLS_SKIP_SET:  needs_flush = bitv;
			IDT_CLS_PLAIN:     needs_flush = 1'b0;
			default:           needs_flush = 1'b0;
		endcase
	endfunction

	// ========================================================================
	// oscillator-phase divider
	typedef enum logic [1:0] {
		IDT_ST_EXEC,
		IDT_ST_STALL,
		IDT_ST_FLUSH
	} idt_state_type;

	localparam logic [1:0] PH_LAST = 2'(CLK_PER_CYCLE - 1);
	localparam logic [1:0] PH_RD   = 2'(IDT_RD_PHASE);

	logic [1:0]    phase_q;
	logic [1:0]    phase_d;
	idt_state_type state_q;
	idt_state_type state_d;
	idt_dec_type   dec_q;
	logic          flush_pend_q;
	logic          flush_pend_d;
	logic [1:0]    count_q;
	logic [1:0]    count_d;
	logic [1:0]    cycles_q;
	logic          done_q;

	wire logic end_w = phase_q == PH_LAST;
	wire logic in_exec_w  = state_q == IDT_ST_EXEC;
	// skip outcome uses the datapath status as it stands at phase 3;
	// the datapath must have alu_zero and tested_bit settled by then
	wire logic flush_w = needs_flush(dec_q, alu_zero, tested_bit);
	// extra cycle when the chosen pointer aims at program memory
	// ptr_in_prog is a level, so a pointer moved by the word itself
	// only counts from the next word on
	wire logic sel_ptr_w   = dec_q.ptr_sel;
	wire logic aims_prog_w = ptr_in_prog[sel_ptr_w];
	wire logic stall_w     = dec_q.indirect && aims_prog_w;

	assign phase_d = end_w ? 2'h0 : phase_q + 2'h1;

	always_ff @(posedge clk) begin
		if (!resetn)
			phase_q <= 2'h0;
		else
			phase_q <= phase_d;
	end

	// ========================================================================
	// instruction cycle sequencer
	// a two-cycle word spends its second cycle on the prefetched word,
	// which is dropped rather than executed: cheaper than undoing it
	always_comb begin
		state_d      = state_q;
		flush_pend_d = flush_pend_q;
		unique case (state_q)
			IDT_ST_EXEC: begin
				flush_pend_d = flush_w;
				if (stall_w)
					state_d = IDT_ST_STALL;
				else if (flush_w)
					state_d = IDT_ST_FLUSH;
				else
					state_d = IDT_ST_EXEC;
			end
			IDT_ST_STALL: begin
				state_d = flush_pend_q ? IDT_ST_FLUSH : IDT_ST_EXEC;
			end
			IDT_ST_FLUSH: begin
				flush_pend_d = 1'b0;
				state_d      = IDT_ST_EXEC;
			end
			// an upset code falls back to a discard cycle, never a word
			default: begin
				flush_pend_d = 1'b0;
				state_d      = IDT_ST_FLUSH;
			end
		endcase
	end

	// ========================================================================
	// word bookkeeping
	// a word loads at a boundary whose next cycle is an execute cycle
	wire logic load_w = end_w && (state_d == IDT_ST_EXEC);

	// the discard cycle after reset belongs to no word, so nothing
	// completes until a first word has really been loaded
	logic       loaded_q;
	logic       loaded_d;
	logic       fin_w;
	logic       done_d;
	logic [1:0] cycles_d;

	assign loaded_d = loaded_q || load_w;

	// a word is finished at the boundary where the next one loads:
	// after its execute, its stall or its discard cycle
	assign fin_w  = load_w && loaded_q;
	assign done_d = fin_w;

	// count_q holds the cycles spent so far on the word in hand,
	// the one now ending included; three at the most
	assign count_d  = load_w ? 2'h1 :
		(end_w ? count_q + 2'h1 : count_q);
	assign cycles_d = fin_w ? count_q : cycles_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q      <= IDT_ST_FLUSH;
			flush_pend_q <= 1'b0;
		end else if (end_w) begin
			state_q      <= state_d;
			flush_pend_q <= flush_pend_d;
		end
	end

	// whole word captured once per word, at its load boundary; flushed words never load
	always_ff @(posedge clk) begin
		if (!resetn)
			dec_q <= '0;
		else if (load_w)
			dec_q <= decode(instr_word);
	end

	// count_q tracks cycles spent on the current word
	always_ff @(posedge clk) begin
		if (!resetn) begin
			loaded_q <= 1'b0;
			count_q  <= 2'h0;
			cycles_q <= 2'h0;
			done_q   <= 1'b0;
		end else begin
			loaded_q <= loaded_d;
			count_q  <= count_d;
			cycles_q <= cycles_d;
			done_q   <= done_d;
		end
	end

	// ========================================================================
	// read-modify-write strobes
	// the read fires for every byte- and bit-format word except clear-accumulator, even pure stores
	wire logic rd_slot_w = phase_q == PH_RD;
	wire logic wr_slot_w = in_exec_w && end_w;
	// stall and discard cycles never strobe: the stored result belongs
	// to the execute cycle alone
	assign file_rd = in_exec_w && rd_slot_w && dec_q.file_acc;
	assign file_wr = wr_slot_w && dec_q.file_wr;
	assign acc_wr  = wr_slot_w && dec_q.acc_wr;

	// ========================================================================
	// outputs
	assign dec          = dec_q;
	assign exec_active  = in_exec_w;
	assign nop_cycle    = state_q == IDT_ST_FLUSH;
	assign stall_cycle  = state_q == IDT_ST_STALL;
	assign phase        = phase_q;
	assign cycle_end    = end_w;
	assign instr_take   = end_w;
	assign instr_done   = done_q;
	assign instr_cycles = cycles_q;

endmodule // idt_instruction_decode_timing

// ---- verification/idt_instruction_decode_timing_test.sv ----
// self-checking bench for instruction decode timing
`timescale 1ns/1ns
module idt_instruction_decode_timing_test;
	import idt_pkg::*;
	// ========================================
	// design hookup
	logic        clk, resetn, instr_take, alu_zero, tested_bit;
	logic [13:0] instr_word;
	logic [1:0]  ptr_in_prog, phase, instr_cycles;
	idt_dec_type dec;
	logic        exec_active, nop_cycle, stall_cycle, cycle_end;
	logic        file_rd, file_wr, acc_wr, instr_done;
	int          bad_count, total_checks;
	logic [13:0] wq[$];
	int          cq[$];
	idt_dec_type dq[16];
	idt_instruction_decode_timing dut (
		.clk, .resetn, .instr_word, .instr_take, .ptr_in_prog, .alu_zero,
		.tested_bit, .dec, .exec_active, .nop_cycle, .stall_cycle, .phase,
		.cycle_end, .file_rd, .file_wr, .acc_wr, .instr_done, .instr_cycles
	);
	idt_prog_mem pm (.clk, .resetn, .instr_take, .instr_word);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ========================================
	// helpers
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// sel 0 waits for execute, sel 1 for completion
	task automatic await(input bit sel);
		int n;
		n = 0;
		while ((sel ? instr_done : exec_active) !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 40) begin
				bad_count++;
				finish_test();
			end
		end
	endtask
	// dropped slots get filler so each word lands where the core fetches it
	task automatic run(input string name, input logic [1:0] ptr,
		input logic z, input logic tb);
		int pos;
		pos = 0;
		foreach (pm.mem[i]) pm.mem[i] = 14'h0000;
		foreach (wq[i]) begin
			pm.mem[pos] = wq[i];
			pos += cq[i];
		end
		@(negedge clk);
		resetn = 1'b0;
		ptr_in_prog = ptr;
		alu_zero = z;
		tested_bit = tb;
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		foreach (wq[i]) begin
			await(1'b0);
			dq[i] = dec;
			await(1'b1);
			chk({12'h000, instr_cycles}, 14'(cq[i]));
			@(negedge clk);
		end
		$display("test %s done", name);
	endtask
	// ========================================
	// scenarios
	task automatic test_single();
		wq = '{14'h07a5, 14'h01c3, 14'h1425, 14'h3e5a, 14'h0b25, 14'h1825,
			14'h0103, 14'h1c25, 14'h17ff};
		cq = '{1, 1, 1, 1, 1, 1, 1, 2, 1};
		run("single", 2'b11, 1'b0, 1'b1);
		chk({7'h00, dq[0].file_addr}, 14'h0025);
		chk({13'h0, dq[0].file_wr}, 14'h0001);
		chk({13'h0, dq[4].acc_wr}, 14'h0001);
		chk({12'h0, dq[1].fmt}, 14'(IDT_FMT_BYTE));
		chk({12'h0, dq[2].fmt}, 14'(IDT_FMT_BIT));
		chk({6'h0, dq[3].literal}, 14'h005a);
		chk({13'h0, dq[6].acc_wr}, 14'h0001);
		chk({11'h0, dq[8].bit_sel}, 14'h0007);
		chk({7'h0, dq[8].file_addr}, 14'h007f);
	endtask
	task automatic test_double();
		wq = '{14'h2123, 14'h000a, 14'h0008, 14'h3455, 14'h0009, 14'h2fff,
			14'h3380, 14'h000b, 14'h0f25, 14'h1825};
		cq = '{2, 2, 2, 2, 2, 2, 2, 2, 2, 2};
		run("double", 2'b00, 1'b1, 1'b0);
		chk({3'h0, dq[0].target}, 14'h0123);
		chk({5'h0, dq[6].offset}, 14'h0180);
		chk({12'h0, dq[3].fmt}, 14'(IDT_FMT_LIT));
	endtask
	task automatic test_indirect();
		wq = '{14'h0780, 14'h0016, 14'h0b80, 14'h0012, 14'h07a5};
		cq = '{2, 2, 3, 2, 1};
		run("indirect", 2'b11, 1'b1, 1'b0);
		chk({13'h0, dq[0].indirect}, 14'h0001);
		wq = '{14'h0016, 14'h0012, 14'h0011, 14'h0017, 14'h0014};
		cq = '{1, 2, 2, 1, 1};
		run("pointer", 2'b01, 1'b0, 1'b0);
		chk({13'h0, dq[0].ptr_sel}, 14'h0001);
		foreach (wq[i])
			chk({12'h0, dq[i].mode}, {12'h0, wq[i][1:0]});
	endtask
	initial begin
		resetn = 1'b0;
		ptr_in_prog = 2'b00;
		alu_zero = 1'b0;
		tested_bit = 1'b0;
		bad_count = 0;
		total_checks = 0;
		test_single();
		test_double();
		test_indirect();
		finish_test();
	end
endmodule // idt_instruction_decode_timing_test

// ---- verification/idt_prog_mem.sv ----
// program memory model that feeds words to the decoder
`timescale 1ns/1ns
module idt_prog_mem (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// fetch side
	input  wire logic        instr_take,
	output logic      [13:0] instr_word
);
	// ========================================
	// storage, loaded by the bench
	logic [13:0] mem [64];
	logic [5:0]  addr_q;
	// one whole word per fetch, opcode and operands together
	assign instr_word = mem[addr_q];
	// advances every cycle, dropped words included
	always_ff @(posedge clk) begin
		if (!resetn)
			addr_q <= 6'h00;
		else if (instr_take)
			addr_q <= addr_q + 6'h01;
	end
endmodule // idt_prog_mem

// ---- verification/idt_timing_asserts.sv ----
// assertions on the decode timing ports
`timescale 1ns/1ns
module idt_timing_chk (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 resetn,
	// fetch and status
	input wire logic                 instr_take,
	input wire logic [1:0]           ptr_in_prog,
	input wire logic                 alu_zero,
	input wire logic                 tested_bit,
	// decode and timing
	input wire idt_pkg::idt_dec_type dec,
	input wire logic                 exec_active,
	input wire logic                 nop_cycle,
	input wire logic                 stall_cycle,
	input wire logic [1:0]           phase,
	input wire logic                 cycle_end,
	input wire logic                 file_rd,
	input wire logic                 file_wr,
	input wire logic                 acc_wr,
	input wire logic                 instr_done
);
	import idt_pkg::*;
	// ========================================
	// common terms
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	wire ends = exec_active && cycle_end;
	wire quiet = !file_rd && !file_wr && !acc_wr;
	sequence s_walk;
		phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3 ##1 phase == 2'h0;
	endsequence
	sequence s_extra;
		nop_cycle || stall_cycle;
	endsequence
	// ========================================
	// checks
	chk_phase_walk: assert property (phase == 2'h0 |=> s_walk)
		else $error("phase walk broken");
	chk_take_end: assert property (instr_take == cycle_end
		&& cycle_end == (phase == 2'h3)) else $error("take off phase three");
	chk_read_first: assert property (file_wr |-> $past(file_rd, 2))
		else $error("file write without read");
	chk_read_slot: assert property (file_rd |->
		phase == 2'h1 && exec_active && dec.file_acc)
		else $error("file read misplaced");
	chk_dest_sel: assert property (ends && dec.fmt == IDT_FMT_BYTE
		|-> file_wr == dec.file_wr && acc_wr == dec.acc_wr)
		else $error("result stored to wrong place");
	chk_two_extra: assert property (ends && dec.cls inside
		{IDT_CLS_CALL, IDT_CLS_RETURN, IDT_CLS_BRANCH} |=> s_extra)
		else $error("two cycle word ended early");
	chk_one_only: assert property (ends && dec.cls == IDT_CLS_PLAIN
		&& !dec.indirect |=> exec_active) else $error("plain word stretched");
	chk_skip_none: assert property (ends && !dec.indirect && (
		(dec.cls == IDT_CLS_SKIP_SET && !tested_bit) ||
		(dec.cls == IDT_CLS_SKIP_CLR && tested_bit) ||
		(dec.cls == IDT_CLS_SKIP_ZERO && !alu_zero)) |=> exec_active)
		else $error("untaken skip stretched");
	chk_stall_add: assert property (ends && dec.indirect &&
		ptr_in_prog[dec.ptr_sel] |=> stall_cycle)
		else $error("indirect stall missing");
	chk_nop_quiet: assert property ($rose(nop_cycle) |->
		quiet throughout nop_cycle[*4]) else $error("discard cycle acted");
	chk_done_end: assert property (instr_done |-> $past(cycle_end))
		else $error("done off cycle end");
endmodule // idt_timing_chk
bind idt_instruction_decode_timing idt_timing_chk u_chk (
	.clk, .resetn, .instr_take, .ptr_in_prog, .alu_zero, .tested_bit, .dec,
	.exec_active, .nop_cycle, .stall_cycle, .phase, .cycle_end, .file_rd,
	.file_wr, .acc_wr, .instr_done
);
